// *** verilog/rtm_pin_ctrl.sv ***
/*
  Top of the reset and test-mode pin control block: test-mode decode, JTAG pin
  routing, GPIO pull control under reset and a small register port.
  Assumes pads resolve GPIO levels from out, active-low enable and pull requests.
*/
// Operation
// RULE_01 - Decode two select pins: normal, JTAG when low bit only, reserved when high bit.
// RULE_02 - JTAG mode routes TCK GPIO5, TDI GPIO8, TDO GPIO7, TMS GPIO6, reset pin.
// RULE_03 - Power-on reset puts every circuit into a defined state.
// RULE_04 - Low external reset pin forces the same state as power-on reset; the select pipeline and mode_q reset on RST_N only.
// RULE_05 - Reset pin has a programmable internal pull-up, may stay unconnected.
// RULE_06 - Board must hold the reset pin low for 100 microseconds.
// RULE_07 - During reset GPIO 3, 4, 5, 6, 7 and 11 are pulled up.
// RULE_08 - During reset GPIO 0, 1, 2, 8, 9, 10, 12 and 13 are pulled down.
// RULE_09 - External reset release is synchronised so all logic leaves reset together.
`timescale 1ns/1ps
`default_nettype none
`include "rtm_consts.svh"

module rtm_pin_ctrl (
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  input  wire logic                    RESET_PIN_N,
  output var  logic                    RESET_PIN_PU,
  input  wire logic                    TEST_SEL_LOW_BIT,
  input  wire logic                    TEST_SEL_HIGH_BIT,
  input  wire logic [`RTM_GPIO_W-1:0]  GPIO_IN,
  output var  logic [`RTM_GPIO_W-1:0]  GPIO_OUT,
  output var  logic [`RTM_GPIO_W-1:0]  GPIO_OE_N,
  output var  logic [`RTM_GPIO_W-1:0]  GPIO_PU,
  output var  logic [`RTM_GPIO_W-1:0]  GPIO_PD,
  input  wire logic [`RTM_GPIO_W-1:0]  CORE_GPIO_OUT,
  input  wire logic [`RTM_GPIO_W-1:0]  CORE_GPIO_OE_N,
  output var  logic [`RTM_GPIO_W-1:0]  CORE_GPIO_IN,
  output var  rtm_pkg::rtm_jtag_t      JTAG,
  input  wire logic                    JTAG_TDO,
  output var  logic                    SYS_RST_N,
  output var  rtm_pkg::rtm_mode_t      MODE,
  input  wire logic [`RTM_ADDR_W-1:0]  REG_ADDR,
  input  wire logic [`RTM_DATA_W-1:0]  REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output var  logic [`RTM_DATA_W-1:0]  REG_RDATA
);

  function automatic rtm_pkg::rtm_mode_t decode_mode(input logic lo, input logic hi);
    rtm_pkg::rtm_mode_t m;
    m = rtm_pkg::RTM_MODE_NORMAL;
    if (hi) begin
      m = rtm_pkg::RTM_MODE_RESERVED;
    end else if (lo) begin
      m = rtm_pkg::RTM_MODE_JTAG;
    end
    return m;
  endfunction

  logic                     sys_rst_n;
  logic                     ext_rst_n;

  rtm_rst_gen u_rst_gen (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ext_pin_n (RESET_PIN_N),
    .ext_rst_n (ext_rst_n),
    .sys_rst_n (sys_rst_n)
  );

  // Test-select pins: three stages, a change counts once stages two and three agree
  logic [1:0]               sel_s1_q, sel_s2_q, sel_s3_q, sel_f_q;
  logic [1:0]               sel_f_d;
  rtm_pkg::rtm_mode_t       mode_q, mode_d;

  always_comb begin
    sel_f_d = (~(sel_s2_q ^ sel_s3_q) & sel_s3_q) | ((sel_s2_q ^ sel_s3_q) & sel_f_q);
    mode_d  = decode_mode(sel_f_q[0], sel_f_q[1]); // RULE_01
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
      sel_s3_q <= 2'h0;
      sel_f_q  <= 2'h0;
      mode_q   <= rtm_pkg::RTM_MODE_NORMAL;
    end else begin
      sel_s1_q <= {TEST_SEL_HIGH_BIT, TEST_SEL_LOW_BIT};
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      sel_f_q  <= sel_f_d;
      mode_q   <= mode_d;
    end
  end

  // Register port; the whole file returns to defaults on any internal reset
  logic                     pu_en_q, pu_en_d;
  logic [`RTM_GPIO_W-1:0]   pull_up_q, pull_up_d;
  logic [`RTM_GPIO_W-1:0]   pull_dn_q, pull_dn_d;
  logic [`RTM_DATA_W-1:0]   rdata_q, rdata_d;
  logic [`RTM_GPIO_W-1:0]   core_out_q, core_out_d;
  logic [`RTM_GPIO_W-1:0]   core_oe_n_q, core_oe_n_d;

  always_comb begin
    pu_en_d     = pu_en_q;
    pull_up_d   = pull_up_q;
    pull_dn_d   = pull_dn_q;
    rdata_d     = '0;
    core_out_d  = CORE_GPIO_OUT;
    core_oe_n_d = CORE_GPIO_OE_N;
    if (REG_WR) begin
      unique case (REG_ADDR)
        `RTM_OFS_CTRL:    pu_en_d   = REG_WDATA[`RTM_CTRL_PU_BIT]; // RULE_05
        `RTM_OFS_PULL_UP: pull_up_d = REG_WDATA[`RTM_GPIO_W-1:0];
        `RTM_OFS_PULL_DN: pull_dn_d = REG_WDATA[`RTM_GPIO_W-1:0];
        default:          pu_en_d   = pu_en_q;
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        `RTM_OFS_CTRL:    rdata_d[`RTM_CTRL_PU_BIT]  = pu_en_q;
        `RTM_OFS_PULL_UP: rdata_d[`RTM_GPIO_W-1:0]   = pull_up_q;
        `RTM_OFS_PULL_DN: rdata_d[`RTM_GPIO_W-1:0]   = pull_dn_q;
        `RTM_OFS_STATUS:  rdata_d[4:0] = {sel_f_q, ext_rst_n, mode_q};
        default:          rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!sys_rst_n) begin
      pu_en_q     <= `RTM_CTRL_RST; // RULE_03
      pull_up_q   <= `RTM_RST_PU_MASK;
      pull_dn_q   <= `RTM_RST_PD_MASK;
      rdata_q     <= '0;
      core_out_q  <= '0;
      core_oe_n_q <= '1;
    end else begin
      pu_en_q     <= pu_en_d;
      pull_up_q   <= pull_up_d;
      pull_dn_q   <= pull_dn_d;
      rdata_q     <= rdata_d;
      core_out_q  <= core_out_d;
      core_oe_n_q <= core_oe_n_d;
    end
  end

  // Pad mux; JTAG path stays combinational since the probe clock is not ours
  logic jtag_on;

  always_comb begin
    jtag_on   = (mode_q == rtm_pkg::RTM_MODE_JTAG) && sys_rst_n;
    GPIO_OUT  = core_out_q;
    GPIO_OE_N = core_oe_n_q;
    GPIO_PU   = pull_up_q;
    GPIO_PD   = pull_dn_q;
    JTAG      = '{tck: 1'b0, tdi: 1'b0, tms: 1'b1, trst_n: 1'b0};
    if (!sys_rst_n) begin
      // Released pads let the fixed pulls define every level
      GPIO_OUT  = '0;
      GPIO_OE_N = '1;
      GPIO_PU   = `RTM_RST_PU_MASK; // RULE_07
      GPIO_PD   = `RTM_RST_PD_MASK; // RULE_08
    end else if (jtag_on) begin
      GPIO_OE_N[`RTM_PIN_TCK] = 1'b1; // RULE_02
      GPIO_OE_N[`RTM_PIN_TMS] = 1'b1;
      GPIO_OE_N[`RTM_PIN_TDI] = 1'b1;
      GPIO_OE_N[`RTM_PIN_TDO] = 1'b0;
      GPIO_OUT[`RTM_PIN_TDO]  = JTAG_TDO;
      JTAG.tck    = GPIO_IN[`RTM_PIN_TCK];
      JTAG.tdi    = GPIO_IN[`RTM_PIN_TDI];
      JTAG.tms    = GPIO_IN[`RTM_PIN_TMS];
      JTAG.trst_n = ext_rst_n;
    end
  end

  // Pull-up forced on in reset so a floating pin cannot hold the device down
  assign RESET_PIN_PU = pu_en_q || !sys_rst_n; // RULE_05
  assign CORE_GPIO_IN = GPIO_IN;
  assign SYS_RST_N    = sys_rst_n; // RULE_04
  assign MODE         = mode_q;
  assign REG_RDATA    = rdata_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_high_sel;
    TEST_SEL_HIGH_BIT [*7];
  endsequence
  sequence s_jtag_sel;
    (TEST_SEL_LOW_BIT && !TEST_SEL_HIGH_BIT) [*7];
  endsequence
  sequence s_normal_sel;
    (!TEST_SEL_LOW_BIT && !TEST_SEL_HIGH_BIT) [*7];
  endsequence

  a_mode_reserved: assert property (s_high_sel |-> mode_q == rtm_pkg::RTM_MODE_RESERVED) // RULE_01
    else $error("high select bit did not give reserved mode");
  a_mode_jtag_sel: assert property (s_jtag_sel |-> mode_q == rtm_pkg::RTM_MODE_JTAG) // RULE_01
    else $error("low select bit alone did not give jtag mode");
  a_mode_normal: assert property (s_normal_sel |-> mode_q == rtm_pkg::RTM_MODE_NORMAL) // RULE_01
    else $error("both select bits low did not give normal mode");
  a_normal_pads: assert property (sys_rst_n && !jtag_on |-> GPIO_OE_N == core_oe_n_q && GPIO_OUT == core_out_q) // RULE_01
    else $error("core pad requests not passed outside jtag mode");
  // Parked outputs keep the TAP in reset while the pads belong to the core
  a_jtag_parked: assert property (!jtag_on |-> JTAG.tms && !JTAG.tck && !JTAG.tdi && !JTAG.trst_n) // RULE_02
    else $error("jtag outputs not parked outside jtag mode");
  a_jtag_tdo_drive: assert property (jtag_on |-> !GPIO_OE_N[`RTM_PIN_TDO] && GPIO_OUT[`RTM_PIN_TDO] == JTAG_TDO) // RULE_02
    else $error("test data out not driven on its pad");
  a_jtag_in_route: assert property (jtag_on |-> JTAG.tck == GPIO_IN[`RTM_PIN_TCK] && JTAG.tdi == GPIO_IN[`RTM_PIN_TDI]
                                     && JTAG.tms == GPIO_IN[`RTM_PIN_TMS] && JTAG.trst_n == ext_rst_n) // RULE_02
    else $error("jtag inputs not routed from their pads");
  a_rst_pull_up: assert property (!sys_rst_n |-> GPIO_PU == `RTM_RST_PU_MASK) // RULE_07
    else $error("wrong pull-ups during reset");
  a_rst_pull_dn: assert property (!sys_rst_n |-> GPIO_PD == `RTM_RST_PD_MASK) // RULE_08
    else $error("wrong pull-downs during reset");
  a_rst_pads_free: assert property (!sys_rst_n |-> GPIO_OE_N == '1 ##1 (!sys_rst_n || core_oe_n_q == '1)) // RULE_03
    else $error("pad driven during reset");
  a_pin_pullup: assert property (!ext_rst_n |=> ##1 RESET_PIN_PU && !SYS_RST_N) // RULE_05
    else $error("reset pin pull-up off or reset missed");
  a_pu_reg_steer: assert property (sys_rst_n && REG_WR && REG_ADDR == `RTM_OFS_CTRL ##1 sys_rst_n
                                   |-> RESET_PIN_PU == $past(REG_WDATA[`RTM_CTRL_PU_BIT])) // RULE_05
    else $error("pull-up enable write not applied");

endmodule // rtm_pin_ctrl

`default_nettype wire

// *** verilog/rtm_consts.svh ***
/*
  Constants of the reset and test-mode pin control block: pin numbers, pull masks,
  register offsets, reset values and timing counts.
  Assumes inclusion by bare name from the block's package and modules.
*/
`ifndef RTM_CONSTS_SVH
`define RTM_CONSTS_SVH

`define RTM_GPIO_W          14
`define RTM_PIN_TCK         5
`define RTM_PIN_TMS         6
`define RTM_PIN_TDO         7
`define RTM_PIN_TDI         8

// Pull states applied while the device is held in reset
`define RTM_RST_PU_MASK     14'h08f8
`define RTM_RST_PD_MASK     14'h3707

`define RTM_ADDR_W          4
`define RTM_DATA_W          32
`define RTM_OFS_CTRL        4'h0
`define RTM_OFS_PULL_UP     4'h4
`define RTM_OFS_PULL_DN     4'h8
`define RTM_OFS_STATUS      4'hc
`define RTM_CTRL_RST        1'h1
`define RTM_CTRL_PU_BIT     0

// Internal reset is stretched this many cycles after every reset source lets go
`define RTM_POR_HOLD_W      5
`define RTM_POR_HOLD_CYC    5'h10

`endif

// *** verilog/rtm_pkg.sv ***
/*
  Types of the reset and test-mode pin control block.
  Assumes rtm_consts.svh is on the include path.
*/
`default_nettype none
`include "rtm_consts.svh"

package rtm_pkg;

  typedef enum logic [1:0] {
    RTM_MODE_NORMAL,
    RTM_MODE_JTAG,
    RTM_MODE_RESERVED
  } rtm_mode_t;

  typedef struct packed {
    logic tck;
    logic tdi;
    logic tms;
    logic trst_n;
  } rtm_jtag_t;

endpackage

`default_nettype wire

// *** verilog/rtm_rst_gen.sv ***
/*
  Reset generator: filters the external reset pin, merges it with the power-on
  reset and releases one stretched, clock-synchronous internal reset.
  Assumes rst_n is the power-on reset level, synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtm_consts.svh"

module rtm_rst_gen (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ext_pin_n,
  output var  logic ext_rst_n,
  output var  logic sys_rst_n
);

  logic                       s1_q, s2_q, s3_q, filt_q;
  logic                       filt_d;
  logic [`RTM_POR_HOLD_W-1:0] cnt_q, cnt_d;
  logic                       sys_q, sys_d;

  always_comb begin
    filt_d = (s2_q == s3_q) ? s3_q : filt_q;
    cnt_d  = cnt_q;
    if (!filt_q) begin
      cnt_d = '0; // RULE_04
    end else if (cnt_q != `RTM_POR_HOLD_CYC) begin
      cnt_d = cnt_q + 1'b1; // RULE_03
    end
    // One register releases every consumer on the same edge
    sys_d = filt_q && (cnt_q == `RTM_POR_HOLD_CYC); // RULE_09
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      filt_q <= 1'b1;
      cnt_q  <= '0;
      sys_q  <= 1'b0;
    end else begin
      s1_q   <= ext_pin_n;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      cnt_q  <= cnt_d;
      sys_q  <= sys_d;
    end
  end

  assign ext_rst_n = filt_q;
  assign sys_rst_n = sys_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ext_forces_rst: assert property (!filt_q |=> !sys_q ##1 !sys_q) // RULE_04
    else $error("external reset did not hold internal reset");
  a_por_hold_time: assert property ($rose(rst_n) |-> !sys_q [*8]) // RULE_03
    else $error("internal reset released too early after power-on");
  a_release_clean: assert property ($rose(sys_q) |-> filt_q && $past(filt_q)) // RULE_09
    else $error("internal reset released while a source was active");

endmodule // rtm_rst_gen

`default_nettype wire

// *** verilog/_unused_placeholder_none.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/rtm_board_mdl.sv ***
/*
  Board-side model: reset source on the reset pin and JTAG probe on the pads.
  Assumes the bench raises go for one cycle to request a reset pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module rtm_board_mdl #(
  parameter int HOLD_CYC = 12500
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [2:0]  jtag_drv,
  input  wire logic        pin_pu,
  output var  logic        reset_pin_n,
  output var  logic [13:0] gpio_lvl
);
  int   hold_q = 0;
  logic tog_q  = 1'b0;

  always @(posedge clk) begin
    tog_q <= ~tog_q;
    if (go) begin
      hold_q <= HOLD_CYC;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
    end
  end

  // Released pin rises only on the pull-up; left floating it reads low
  always_comb begin
    reset_pin_n = (hold_q == 0) && pin_pu;
  end

  // Undriven pads toggle so stale values never pass
  always_comb begin
    gpio_lvl    = {14{tog_q}};
    gpio_lvl[5] = jtag_drv[2];
    gpio_lvl[6] = jtag_drv[1];
    gpio_lvl[8] = jtag_drv[0];
  end
endmodule // rtm_board_mdl

`default_nettype wire

// *** tb/rtm_pin_ctrl_tb.sv ***
/*
  Self-checking bench of the reset and test-mode pin control block.
  Assumes the board model in rtm_board_mdl.sv and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtm_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module rtm_pin_ctrl_tb;
  logic CLK = 1'b0, RST_N = 1'b0, SEL_LO = 1'b0, SEL_HI = 1'b0, JTAG_TDO = 1'b0;
  logic REG_WR = 1'b0, REG_RD = 1'b0, go = 1'b0;
  logic [13:0] CORE_OUT = 14'h1555, CORE_OE_N = 14'h0, GPIO_OUT, GPIO_OE_N, GPIO_PU, GPIO_PD, GPIO_IN, CORE_IN;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
  logic [2:0] jtag_drv = 3'h0;
  logic RESET_PIN_N, RESET_PIN_PU, SYS_RST_N;
  rtm_pkg::rtm_jtag_t JTAG;
  rtm_pkg::rtm_mode_t MODE;
  int n_errors = 0, compares = 0;

  always #4 CLK = ~CLK;

  rtm_board_mdl rtm_board_mdl_i (.clk(CLK), .go(go), .jtag_drv(jtag_drv), .pin_pu(RESET_PIN_PU),
    .reset_pin_n(RESET_PIN_N), .gpio_lvl(GPIO_IN));
  rtm_pin_ctrl rtm_pin_ctrl_i (.CLK(CLK), .RST_N(RST_N), .RESET_PIN_N(RESET_PIN_N), .RESET_PIN_PU(RESET_PIN_PU),
    .TEST_SEL_LOW_BIT(SEL_LO), .TEST_SEL_HIGH_BIT(SEL_HI), .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT),
    .GPIO_OE_N(GPIO_OE_N), .GPIO_PU(GPIO_PU), .GPIO_PD(GPIO_PD), .CORE_GPIO_OUT(CORE_OUT),
    .CORE_GPIO_OE_N(CORE_OE_N), .CORE_GPIO_IN(CORE_IN), .JTAG(JTAG), .JTAG_TDO(JTAG_TDO),
    .SYS_RST_N(SYS_RST_N), .MODE(MODE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CLK);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge CLK);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask

  // Pulls and drivers while reset holds the device
  task automatic chk_in_reset();
    `CHK(SYS_RST_N, 1'b0)
    `CHK(GPIO_PU, 14'h08f8)
    `CHK(GPIO_PD, 14'h3707)
    `CHK(GPIO_OE_N, 14'h3fff)
    `CHK(RESET_PIN_PU, 1'b1)
  endtask

  // Internal reset must stay low for the whole stretch, then leave within 100 cycles
  task automatic wait_release();
    int i;
    for (i = 0; i < 100 && SYS_RST_N !== 1'b1; i++) @(posedge CLK);
    `CHK(i >= 16, 1'b1)
    `CHK(SYS_RST_N, 1'b1)
    #1;
  endtask

  task automatic t_por();
    repeat (10) @(posedge CLK);
    #1 chk_in_reset();
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    wait_release();
    rd(4'h4, d);
    `CHK(d, 32'h08f8)
    rd(4'h8, d);
    `CHK(d, 32'h3707)
  endtask

  task automatic t_modes();
    rtm_pkg::rtm_mode_t m;
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      SEL_LO <= i[0]; SEL_HI <= i[1];
      m = i[1] ? rtm_pkg::RTM_MODE_RESERVED : (i[0] ? rtm_pkg::RTM_MODE_JTAG : rtm_pkg::RTM_MODE_NORMAL);
      repeat (7) @(posedge CLK);
      #1 `CHK(MODE, m)
      `CHK(GPIO_OUT, 14'h1555)
      `CHK(GPIO_OE_N, (i == 1) ? 14'h0160 : 14'h0000)
      `CHK(JTAG, (i == 1) ? 4'h1 : 4'h2)
      `CHK(CORE_IN, GPIO_IN)
      rd(4'hc, d);
      `CHK(d, {27'h0, i[1], i[0], 1'b1, m})
    end
  endtask

  task automatic t_jtag();
    @(posedge CLK);
    SEL_LO <= 1'b1; SEL_HI <= 1'b0;
    repeat (7) @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      jtag_drv <= i[2:0]; JTAG_TDO <= ~i[0];
      @(posedge CLK);
      #1 `CHK(JTAG, {i[2], i[0], i[1], 1'b1})
      `CHK(GPIO_OUT[7], ~i[0])
      `CHK(GPIO_OE_N[7], 1'b0)
    end
    @(posedge CLK);
    SEL_LO <= 1'b0;
    repeat (7) @(posedge CLK);
  endtask

  // Pull-up register cleared first so the reset pin must restore it
  task automatic t_pin_reset();
    int i;
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h0);
    #1 `CHK(GPIO_PU, 14'h0)
    `CHK(RESET_PIN_PU, 1'b0)
    @(posedge CLK);
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    repeat (20) @(posedge CLK);
    #1 chk_in_reset();
    for (i = 0; i < 13000 && RESET_PIN_N !== 1'b1; i++) @(posedge CLK);
    wait_release();
    rd(4'h4, d);
    `CHK(d, 32'h08f8)
    rd(4'h0, d);
    `CHK(d, 32'h1)
    wr(4'h2, 32'hffffffff);
    rd(4'h2, d);
    `CHK(d, 32'h0)
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(8 * 30000);
    n_errors++;
    final_report();
  end

  initial begin
    t_por();
    t_modes();
    t_jtag();
    t_pin_reset();
    final_report();
  end
endmodule // rtm_pin_ctrl_tb

`default_nettype wire
